// ===== src/edram_block_ctrl.sv
/*
 * Control for one embedded-DRAM memory block: page activate, precharge and close,
 * refresh scheduling, register decode and the background command stepper.
 * Assumes the buffer/cache logic presents octal-word requests and picks the
 * 32/64/128-bit part of each itself; all inputs are synchronous to clk.
 */
module edram_block_ctrl
	import edram_pkg::*;
#(
	parameter logic [3:0] BLOCK_ID = 4'h0     // Instance number of this block
) (
	input  wire logic          clk,
	input  wire logic          reset,
	output logic               dram_clk_en,      // Half-rate DRAM clock enable
	input  wire logic          oct_valid,        // Octal request from buffers
	output logic               oct_ready,
	input  wire logic          oct_write,
	input  wire logic          oct_last,         // Last octal of a write burst
	input  wire logic [13:0]   oct_addr,         // Address bits 16..3
	input  wire logic [255:0]  oct_wdata,
	output logic               rd_valid,
	output logic [255:0]       rd_data,
	output logic               pf_fill,          // Copy open page to prefetch buffer
	output logic [10:0]        pf_page,          // Address bits 16..6
	input  wire logic [3:0]    reg_block,        // Register instance addressed
	input  wire logic          cmd_wr,
	input  wire logic          addr_wr,
	input  wire logic [31:0]   reg_wdata,
	output logic [31:0]        cache_status_reg,
	output logic               cmd_exec,         // Immediate command strobe
	output logic [5:0]         cmd_op,
	input  wire logic          core_sys_req,
	input  wire logic          fetch_req,
	output logic               fetch_grant,
	output logic               bg_step,
	output logic [5:0]         bg_op,
	output logic [13:0]        bg_addr
);
	// Only the even instance numbers up to ten exist; broadcast is not a block
	if (BLOCK_ID[0] || (BLOCK_ID > 4'hA)) begin
		$error("BLOCK_ID must be 0, 2, 4, 6, 8 or 10");
	end

	// Storage, one 256-bit entry per octal word
	logic [255:0]      mem_q [OCTALS];                 // [R1]
	// Engine state
	state_e            st_q, st_d;
	logic [2:0]        cnt_q, cnt_d;                   // Cycles spent in SYNC, PRE, ACT or REF; 0 otherwise
	logic [3:0]        open_q, open_d;                 // Page buffer holds a page
	logic [8:0]        row_q [SUBARRAYS];              // Open page per sub-array
	logic [8:0]        row_d [SUBARRAYS];
	logic              req_wr_q, req_wr_d;
	logic              req_last_q, req_last_d;
	logic [13:0]       req_addr_q, req_addr_d;
	logic [255:0]      req_data_q, req_data_d;
	logic              close_q, close_d;               // Precharge then idle
	logic              refgo_q, refgo_d;               // Precharge then refresh
	logic              rdv_d, pff_d;
	logic              dram_clk_q;
	// Refresh timer
	logic [RATE_W-1:0] rate_q, rate_d;
	logic [RATE_W-1:0] rcnt_q, rcnt_d;
	logic              rpend_q, rpend_d;
	// Register and background state
	logic [2:0]        stall_q, stall_d;
	logic [13:0]       air_q, air_d;                   // Address/index register
	logic              bg_act_q, bg_act_d;
	logic [8:0]        bg_len_q, bg_len_d;
	logic [5:0]        bg_op_q, bg_op_d;
	logic [13:0]       bg_ptr_q, bg_ptr_d;
	logic              turn_q, turn_d;                 // 1: fetch had last conflict
	logic              cexe_d;
	logic [5:0]        cop_q, cop_d;

	// Decode of incoming request
	logic       sel_hit, reg_hit, rd_block, bg_ok, start_ok;
	logic [1:0] in_sa;
	logic [8:0] in_row;
	logic [1:0] rq_sa;
	logic [5:0] wop;

	// Sub-array is half-block bit 16 with interleave bit 6
	assign in_sa    = {oct_addr[13], oct_addr[3]};    // [R2] [R3]
	assign in_row   = {oct_addr[12:4]};               // [R4]
	assign rq_sa    = {req_addr_q[13], req_addr_q[3]};
	assign sel_hit  = (reg_block == BLOCK_ID) || (reg_block == BCAST_ID);  // [R15]
	assign reg_hit  = sel_hit && (cmd_wr || addr_wr);
	assign wop      = reg_wdata[OP_LSB +: 6];
	assign rd_block = (stall_q != 3'h0) && !oct_write;                     // [R16]
	assign start_ok = !rpend_q && !rd_block;
	assign oct_ready = (st_q == ST_IDLE) && start_ok;  // [R9] [R25]
	assign dram_clk_en = dram_clk_q;                          // [R8]

	// Background arbitration: core/system first, fetch and command take turns
	assign bg_ok       = bg_act_q && !core_sys_req && !(fetch_req && !turn_q);  // [R20]
	assign fetch_grant = fetch_req && !core_sys_req && !(bg_act_q && turn_q);   // [R20]
	assign bg_step     = bg_ok;
	assign bg_op       = bg_op_q;
	assign bg_addr     = bg_ptr_q;

	// Status is assembled from live state; no write path exists
	assign cache_status_reg = {26'h0, open_q, rpend_q, bg_act_q};  // [R17]
	assign cmd_op = cop_q;

	// Page engine next state
	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q + 3'h1;
		open_d     = open_q;
		row_d      = row_q;
		req_wr_d   = req_wr_q;
		req_last_d = req_last_q;
		req_addr_d = req_addr_q;
		req_data_d = req_data_q;
		close_d    = close_q;
		refgo_d    = refgo_q;
		rdv_d      = 1'b0;
		pff_d      = 1'b0;
		case (st_q)
			ST_IDLE: begin
				cnt_d = 3'h0;
				if (rpend_q) begin
					// Refresh goes in between accesses, closing pages first
					refgo_d = 1'b1;                                  // [R25]
					st_d    = (open_q != 4'h0) ? ST_SYNC : ST_REF;
				end else if (oct_valid && oct_ready) begin
					req_wr_d   = oct_write;
					req_last_d = oct_last;
					req_addr_d = oct_addr;
					req_data_d = oct_wdata;
					close_d    = 1'b0;
					if (open_q[in_sa] && row_q[in_sa] == in_row) begin
						st_d = ST_XFER;                              // [R11]
					end else if (open_q[in_sa]) begin
						st_d = ST_SYNC;                              // [R12]
					end else begin
						// Other sub-arrays keep their pages open
						st_d = ST_ACT;                               // [R10]
					end
				end
			end
			ST_SYNC: begin
				if (cnt_q == 3'(SYNC_CYCLES - 1)) begin
					st_d  = ST_PRE;                                  // [R7]
					cnt_d = 3'h0;
				end
			end
			ST_PRE: begin
				if (cnt_q == 3'(PRE_CYCLES - 1)) begin
					cnt_d = 3'h0;
					if (refgo_q) begin
						open_d = 4'h0;
						st_d   = ST_REF;
					end else begin
						open_d[rq_sa] = 1'b0;
						st_d = close_q ? ST_IDLE : ST_ACT;            // [R12]
					end
				end
			end
			ST_ACT: begin
				if (cnt_q == 3'(ACT_CYCLES - 1)) begin
					open_d[rq_sa] = 1'b1;                            // [R11]
					row_d[rq_sa]  = req_addr_q[12:4];
					pff_d = !req_wr_q;                               // [R5]
					st_d  = ST_XFER;
					cnt_d = 3'h0;
				end
			end
			ST_XFER: begin
				cnt_d = 3'h0;
				if (dram_clk_q) begin
					// One 256-bit beat per DRAM clock
					rdv_d = !req_wr_q;                               // [R8]
					if (req_wr_q && req_last_q) begin
						close_d = 1'b1;                              // [R6]
						st_d    = ST_SYNC;
					end else begin
						st_d = ST_IDLE;
					end
				end
			end
			ST_REF: begin
				if (cnt_q == 3'(REF_CYCLES - 1)) begin
					refgo_d = 1'b0;                                  // [R14]
					st_d    = ST_IDLE;
					cnt_d   = 3'h0;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// Refresh timer, register decode and background stepper next state
	always_comb begin
		rate_d   = rate_q;
		rcnt_d   = rcnt_q - RATE_W'(1);
		rpend_d  = rpend_q;
		stall_d  = (stall_q != 3'h0) ? stall_q - 3'h1 : 3'h0;
		air_d    = air_q;
		bg_act_d = bg_act_q;
		bg_len_d = bg_len_q;
		bg_op_d  = bg_op_q;
		bg_ptr_d = bg_ptr_q;
		turn_d   = turn_q;
		cexe_d   = 1'b0;
		cop_d    = cop_q;
		if (rcnt_q == RATE_W'(0)) begin
			rcnt_d  = rate_q;
			rpend_d = 1'b1;                                          // [R13] [R25]
		end
		// Clear as the refresh starts, so an expiry during it stays queued
		if (st_q != ST_REF && st_d == ST_REF) begin
			rpend_d = (rcnt_q == RATE_W'(0));                        // Set wins over clear [R25]
		end
		if (reg_hit) begin
			stall_d = 3'(REG_STALL_CYCLES);                          // [R16]
		end
		// Address register writes are blocked while a long command runs
		if (sel_hit && addr_wr && !bg_act_q) begin
			air_d = reg_wdata[16:3];                                 // [R22] [R23]
		end
		if (sel_hit && cmd_wr && !bg_act_q) begin
			cexe_d = 1'b1;                                           // [R18]
			cop_d  = wop;
			if (wop == OP_REFRESH) begin
				rate_d = reg_wdata[RATE_W-1:0];                      // [R14]
				rcnt_d = reg_wdata[RATE_W-1:0];
			end
			if (wop == OP_INIT || wop == OP_INIT_LOCK || wop == OP_COPYBACK ||
				wop == OP_INVAL) begin
				bg_act_d = 1'b1;                                     // [R19] [R21]
				bg_op_d  = wop;
				bg_len_d = reg_wdata[LEN_LSB +: 9];
				// Initialise walks addresses; the others walk set indices
				bg_ptr_d = (wop[4]) ? air_q : {air_q[13:7], 7'h00};  // [R24]
			end
		end else if (bg_ok) begin
			bg_ptr_d = bg_op_q[4] ? bg_ptr_q + 14'h0001 : bg_ptr_q + 14'h0080;
			bg_len_d = bg_len_q - 9'h001;
			if (bg_len_q <= 9'h001) begin
				bg_act_d = 1'b0;
			end
		end
		if (fetch_req && bg_act_q && !core_sys_req) begin
			turn_d = !turn_q;                                        // [R20]
		end
	end

	// Register all control state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q       <= ST_IDLE;
			cnt_q      <= 3'h0;
			open_q     <= 4'h0;
			req_wr_q   <= 1'b0;
			req_last_q <= 1'b0;
			req_addr_q <= 14'h0000;
			req_data_q <= 256'h0;
			close_q    <= 1'b0;
			refgo_q    <= 1'b0;
			rd_valid   <= 1'b0;
			pf_fill    <= 1'b0;
			dram_clk_q     <= 1'b0;
			rate_q     <= RATE_RESET;
			rcnt_q     <= RATE_RESET;
			rpend_q    <= 1'b0;
			stall_q    <= 3'h0;
			air_q      <= 14'h0000;
			bg_act_q   <= 1'b0;
			bg_len_q   <= 9'h000;
			bg_op_q    <= 6'h00;
			bg_ptr_q   <= 14'h0000;
			turn_q     <= 1'b0;
			cmd_exec   <= 1'b0;
			cop_q      <= 6'h00;
			for (int i = 0; i < SUBARRAYS; i++) begin
				row_q[i] <= 9'h000;
			end
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			open_q     <= open_d;
			req_wr_q   <= req_wr_d;
			req_last_q <= req_last_d;
			req_addr_q <= req_addr_d;
			req_data_q <= req_data_d;
			close_q    <= close_d;
			refgo_q    <= refgo_d;
			rd_valid   <= rdv_d;
			pf_fill    <= pff_d;
			dram_clk_q     <= !dram_clk_q;
			rate_q     <= rate_d;
			rcnt_q     <= rcnt_d;
			rpend_q    <= rpend_d;
			stall_q    <= stall_d;
			air_q      <= air_d;
			bg_act_q   <= bg_act_d;
			bg_len_q   <= bg_len_d;
			bg_op_q    <= bg_op_d;
			bg_ptr_q   <= bg_ptr_d;
			turn_q     <= turn_d;
			cmd_exec   <= cexe_d;
			cop_q      <= cop_d;
			row_q      <= row_d;
		end
	end

	// Array and data path; storage has no reset by intent
	always_ff @(posedge clk) begin
		if (st_q == ST_XFER && dram_clk_q) begin
			if (req_wr_q) begin
				mem_q[req_addr_q] <= req_data_q;                     // [R6]
			end else begin
				rd_data <= mem_q[req_addr_q];                        // [R8]
			end
		end
		if (st_q == ST_ACT) begin
			pf_page <= req_addr_q[13:3];
		end
	end

	// Checks
	chk_act_two: assert property (@(posedge clk) disable iff (reset)   // [R11]
		(st_q == ST_ACT && $past(st_q) != ST_ACT) |-> ##1 st_q == ST_ACT ##1 st_q == ST_XFER)
		else $error("activate not two cycles");
	chk_pre_two: assert property (@(posedge clk) disable iff (reset)   // [R12]
		(st_q == ST_PRE && $past(st_q) != ST_PRE) |-> ##1 st_q == ST_PRE ##1 st_q != ST_PRE)
		else $error("precharge not two cycles");
	chk_sync_first: assert property (@(posedge clk) disable iff (reset)  // [R7]
		(st_q == ST_PRE && $past(st_q) != ST_PRE) |-> $past(st_q, 2) == ST_SYNC)
		else $error("precharge without synchronisation");
	chk_ref_six: assert property (@(posedge clk) disable iff (reset)   // [R14]
		(st_q == ST_REF && $past(st_q) != ST_REF) |-> (st_q == ST_REF) [*6] ##1 st_q == ST_IDLE)
		else $error("refresh not six cycles");
	chk_reg_stall: assert property (@(posedge clk) disable iff (reset)  // [R16]
		reg_hit |=> (!oct_ready || oct_write) [*4])
		else $error("read accepted during register stall");
	chk_ref_queued: assert property (@(posedge clk) disable iff (reset)  // [R25]
		(rcnt_q == RATE_W'(0)) |=> rpend_q ##[0:40] st_q == ST_REF)
		else $error("refresh request lost");
	chk_write_close: assert property (@(posedge clk) disable iff (reset)  // [R6]
		(st_q == ST_XFER && dram_clk_q && req_wr_q && req_last_q) |=> st_q == ST_SYNC ##2 st_q == ST_PRE)
		else $error("write burst did not close page");
	chk_core_wins: assert property (@(posedge clk) disable iff (reset)  // [R20]
		core_sys_req |-> !bg_step && !fetch_grant)
		else $error("background beat core access");
	chk_turns: assert property (@(posedge clk) disable iff (reset)     // [R20]
		(fetch_req && bg_act_q && !core_sys_req && fetch_grant) ##1
		(fetch_req && bg_act_q && !core_sys_req) |-> bg_step)
		else $error("fetch took two turns in a row");
	chk_hit_direct: assert property (@(posedge clk) disable iff (reset)  // [R10]
		(oct_valid && oct_ready && open_q[in_sa] && row_q[in_sa] == in_row) |=> st_q == ST_XFER)
		else $error("open page reactivated");
	cov_refresh: cover property (@(posedge clk) disable iff (reset) st_q == ST_REF);
	cov_swap: cover property (@(posedge clk) disable iff (reset)
		st_q == ST_PRE ##2 st_q == ST_ACT);
	cov_bg_done: cover property (@(posedge clk) disable iff (reset) $fell(bg_act_q));
	cov_prefetch: cover property (@(posedge clk) disable iff (reset) pf_fill);
endmodule

// ===== src/edram_pkg.sv
/*
 * Constants, command codes and state encoding for the embedded-DRAM block control.
 * Assumes a single 100 MHz core clock; the DRAM side runs on a half-rate enable.
 */
// What this block does
// R1: Block holds 128K words, one access per cycle
// R2: Two half-blocks, each with private buffers
// R3: Two interleaved 32K-word sub-arrays per half-block
// R4: Per sub-array page buffer, 512 pages each
// R5: Read miss loads page, copies to prefetch
// R6: Writes open page, stream octals, then close
// R7: Synchronisation step before every page close
// R8: DRAM clock half rate, 256-bit transfers
// R9: Accept one up-to-128-bit access per clock; the code takes at most one octal every two clocks
// R10: Other sub-array pages stay open meanwhile
// R11: Activate takes two clocks, then buffer serves
// R12: Same sub-array page swap needs precharge, activate
// R13: Refresh every location within 3.2 ms
// R14: Refresh takes six clocks at programmed rate
// R15: Registers per block 0..10, B broadcasts
// R16: Read after command/address write stalls four
// R17: Cache status register is read-only
// R18: Command takes effect when register written
// R19: Init, copyback, invalidate run in background
// R20: Core/system beat background; fetch alternates turns
// R21: Load address register before long commands
// R22: Address register written only by transfer
// R23: No register change during long command
// R24: Address bits 16..3 or index 16..10
// R25: Refresh request queued, never skipped
package edram_pkg;
	localparam int  CLK_MHZ          = 100;       // Core clock rate
	localparam real RETENTION_MS     = 3.2;       // Cell retention limit
	localparam real REFRESH_US       = 1.6;       // Interval between refresh operations
	localparam int  REFRESH_CYCLES   = int'($floor(REFRESH_US * CLK_MHZ));
	localparam int  ACT_CYCLES       = 2;         // Activate latency
	localparam int  PRE_CYCLES       = 2;         // Precharge write-back
	localparam int  SYNC_CYCLES      = 2;         // Sync before close, worst case taken
	localparam int  REF_CYCLES       = 6;         // One refresh operation
	localparam int  REG_STALL_CYCLES = 4;         // Read stall after register write
	localparam int  OCTALS           = 16384;     // 128K words as 256-bit entries
	localparam int  PAGES_PER_SA     = 512;
	localparam int  SUBARRAYS        = 4;
	// Command word layout
	localparam int  OP_LSB    = 26;
	localparam int  LEN_LSB   = 15;
	localparam int  STALL_BIT = 14;
	localparam int  RATE_W    = 14;
	localparam int  IDX_LSB   = 10;               // Index field low bit in address terms
	localparam logic [3:0] BCAST_ID = 4'hB;      // Broadcast instance
	// Opcodes
	localparam logic [5:0] OP_REFRESH   = 6'h14;
	localparam logic [5:0] OP_INIT      = 6'h10;
	localparam logic [5:0] OP_INIT_LOCK = 6'h11;
	localparam logic [5:0] OP_COPYBACK  = 6'h04;
	localparam logic [5:0] OP_INVAL     = 6'h05;
	// Reset value of the refresh interval
	localparam logic [RATE_W-1:0] RATE_RESET = RATE_W'(REFRESH_CYCLES);
	// Status bit positions; the open flags start at bit 2, not at ST_OPEN
	localparam int  ST_ACTIVE  = 0;
	localparam int  ST_REFPEND = 1;
	localparam int  ST_OPEN    = 4;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SYNC = 6'h02,
		ST_PRE  = 6'h04,
		ST_ACT  = 6'h08,
		ST_XFER = 6'h10,
		ST_REF  = 6'h20
	} state_e;
endpackage

// ===== tb/octal_requester.sv
/*
 * Requester model for the octal port: stands where the prefetch, read and
 * copyback buffers sit. Assumes one clock; requests change only at rising edges.
 */
module octal_requester
	import edram_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   oct_ready,
	output logic        oct_valid,
	output logic        oct_write,
	output logic        oct_last,
	output logic [13:0] oct_addr,
	output logic [255:0] oct_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle at time zero
	initial begin
		oct_valid = 1'b0;
		oct_write = 1'b0;
		oct_last = 1'b0;
		oct_addr = 14'h0000;
		oct_wdata = '0;
	end
	// One octal, held until taken; waited is -1 when the bound runs out
	task automatic send(input logic w, input logic last, input logic [13:0] a,
		input logic [255:0] d, output int waited);
		int i;
		@(posedge clk);
		oct_valid <= 1'b1;
		oct_write <= w;
		oct_last <= last; // Burst ends on the final octal
		oct_addr <= a;
		oct_wdata <= d;
		waited = -1;
		// Ready is settled at the falling edge, so the take edge is known
		for (i = 0; i < 400; i++) begin
			@(negedge clk);
			if (oct_ready === 1'b1) begin
				waited = i;
				break;
			end
		end
		@(posedge clk);
		oct_valid <= 1'b0;
		// Released address, data and last lines never show the last value; oct_write keeps it
		oct_addr <= ~a;
		oct_wdata <= ~d;
		oct_last <= ~last;
	endtask
endmodule

// ===== tb/tb_top.sv
/*
 * Self-checking bench for the embedded-DRAM block control.
 * Assumes octal_requester drives the octal port; the bench drives registers.
 */
module tb_top;
	import edram_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] ME = 4'h4;     // Instance number given to the block
	logic         clk = 1'b0, reset = 1'b1;
	logic         oct_valid, oct_write, oct_last, oct_ready;
	logic         dram_clk_en, rd_valid, pf_fill, cmd_exec, fetch_grant, bg_step;
	logic         cmd_wr = 1'b0, addr_wr = 1'b0, core_sys_req = 1'b0, fetch_req = 1'b0;
	logic [3:0]   reg_block = 4'h0;
	logic [31:0]  reg_wdata = 32'h0, cache_status_reg;
	logic [255:0] oct_wdata, rd_data;
	logic [13:0]  oct_addr, bg_addr;
	logic [10:0]  pf_page;
	logic [5:0]   cmd_op, bg_op;
	logic [255:0] rd_q[$];      // Expected read data, oldest first
	logic [10:0]  pf_q[$];      // Expected prefetch copies
	logic [255:0] mem[int];     // Shadow of written octals
	logic [8:0]   orow[4];      // Open row per sub-array
	logic         ov[4] = '{default: 1'b0};
	logic         dprev = 1'b0;
	logic         armed = 1'b0;   // One negedge out of reset seen
	int           errors = 0, n_tests = 0;
	always #5 clk = ~clk;
	edram_block_ctrl #(.BLOCK_ID(ME)) u_dut (.clk(clk), .reset(reset),
		.dram_clk_en(dram_clk_en), .oct_valid(oct_valid), .oct_ready(oct_ready),
		.oct_write(oct_write), .oct_last(oct_last), .oct_addr(oct_addr),
		.oct_wdata(oct_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .pf_fill(pf_fill),
		.pf_page(pf_page), .reg_block(reg_block), .cmd_wr(cmd_wr), .addr_wr(addr_wr),
		.reg_wdata(reg_wdata), .cache_status_reg(cache_status_reg), .cmd_exec(cmd_exec),
		.cmd_op(cmd_op), .core_sys_req(core_sys_req), .fetch_req(fetch_req),
		.fetch_grant(fetch_grant), .bg_step(bg_step), .bg_op(bg_op), .bg_addr(bg_addr));
	octal_requester u_req (.clk(clk), .oct_ready(oct_ready), .oct_valid(oct_valid),
		.oct_write(oct_write), .oct_last(oct_last), .oct_addr(oct_addr),
		.oct_wdata(oct_wdata));
	task automatic check(input string nm, input logic [255:0] e, input logic [255:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	function automatic logic [31:0] cmdw(logic [5:0] op, logic [8:0] len, logic [13:0] r);
		return {op, 2'b00, len, 1'b0, r};
	endfunction
	// One-cycle register strobe; returns just after the take edge
	task automatic reg_wr(input logic [3:0] blk, input logic a, input logic [31:0] d);
		@(posedge clk);
		reg_block <= blk;
		addr_wr <= a;
		cmd_wr <= ~a;
		reg_wdata <= d;
		@(posedge clk);
		cmd_wr <= 1'b0;
		addr_wr <= 1'b0;
		reg_wdata <= ~d;
		#1;
	endtask
	// Octal transfer with page model: a read miss means a fresh activate and a prefetch copy
	task automatic octal(input logic w, input logic last, input logic [13:0] a);
		int sa, t;
		logic [255:0] d;
		sa = int'({a[13], a[3]});
		d = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		if (w) begin
			mem[int'(a)] = d;
			ov[sa] = ~last; // Page closes after the burst
			orow[sa] = a[12:4];
		end else begin
			rd_q.push_back(mem[int'(a)]);
			if (!(ov[sa] && orow[sa] == a[12:4])) begin
				pf_q.push_back(a[13:3]);
			end
			ov[sa] = 1'b1;
			orow[sa] = a[12:4];
		end
		u_req.send(w, last, a, d, t);
		if (t < 0) begin
			check("octal_taken", 1, 0);
			tally_and_finish();
		end
	endtask
	// Results are matched against the oldest note as they appear
	always @(negedge clk) begin
		// The first cycle out of reset has no previous phase to compare with
		if (!reset && armed) begin
			check("dram_clk_en", !dprev, dram_clk_en);
		end
		armed = !reset;
		dprev = dram_clk_en;
		if (rd_valid === 1'b1) begin
			check("rd_data", rd_q.size() ? rd_q.pop_front() : 'x, rd_data);
		end
		if (pf_fill === 1'b1) begin
			check("pf_page", pf_q.size() ? pf_q.pop_front() : 'x, pf_page);
		end
	end
	initial begin
		logic [13:0] a, b, c, e0;
		logic [31:0] x;
		logic [5:0]  ops[4];
		int i, k, st, t0;
		logic pv;
		ops = '{OP_INIT, OP_INIT_LOCK, OP_COPYBACK, OP_INVAL};
		void'($urandom(32'h4f3a6aa9));
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		// Own block, other block, broadcast; the last leaves a long refresh interval
		for (i = 0; i < 3; i++) begin
			reg_wr(i == 0 ? ME : (i == 1 ? 4'h2 : BCAST_ID), 1'b0, cmdw(OP_REFRESH, 0, 14'h3FFF));
			check("cmd_exec", i != 1, cmd_exec);
		end
		check("cmd_op", OP_REFRESH, cmd_op);
		fetch_req <= 1'b1;
		// Background commands: core access holds them off, fetch takes turns
		for (i = 0; i < 4; i++) begin
			for (k = 0; k < 200 && cache_status_reg[ST_ACTIVE] !== 1'b0; k++) @(posedge clk);
			check("bg_idle", 0, cache_status_reg[ST_ACTIVE]);
			core_sys_req <= 1'b1;
			x = $urandom;
			reg_wr(ME, 1'b1, x);
			reg_wr(ME, 1'b0, cmdw(ops[i], 9'h002, 14'h0000));
			e0 = (i < 2) ? x[16:3] : {x[16:10], 7'h00};
			for (k = 0; k < 4; k++) begin
				@(negedge clk);
				check("bg_held", 0, {bg_step, fetch_grant});
			end
			check("active", 1, cache_status_reg[ST_ACTIVE]);
			// A command written while one runs is dropped
			reg_wr(ME, 1'b0, cmdw(OP_REFRESH, 9'h000, 14'h3FFF));
			check("cmd_refused", 0, cmd_exec);
			check("cmd_op_kept", ops[i], cmd_op);
			@(posedge clk);
			core_sys_req <= 1'b0;
			st = 0;
			pv = 1'b0;
			for (k = 0; k < 100 && cache_status_reg[ST_ACTIVE] === 1'b1; k++) begin
				@(negedge clk);
				if (bg_step === 1'b1 && st == 0) check("bg_addr", e0, bg_addr);
				if (bg_step === 1'b1) check("bg_op", ops[i], bg_op);
				check("turns", 0, {bg_step & fetch_grant, bg_step & pv});
				pv = bg_step;
				st += (bg_step === 1'b1);
			end
			check("bg_steps", 2, st);
		end
		fetch_req <= 1'b0;
		repeat (200) @(posedge clk);
		// Pages: burst write, hits, other half-block kept open, same sub-array swap
		for (i = 0; i < 3; i++) begin
			a = {1'b0, 9'($urandom), 1'b0, 3'($urandom % 6)};
			b = {1'b1, 9'($urandom), 1'b0, 3'h0};
			c = {1'b0, a[12:4] + 9'h001, 1'b0, 3'h7};
			for (k = 0; k < 3; k++) octal(1'b1, k == 2, a + 14'(k));
			octal(1'b0, 1'b0, a + 14'h1);
			octal(1'b0, 1'b0, a + 14'h2);
			octal(1'b1, 1'b1, b);
			octal(1'b0, 1'b0, b);
			octal(1'b0, 1'b0, a);
			octal(1'b1, 1'b1, c);
			octal(1'b0, 1'b0, c);
			octal(1'b0, 1'b0, a);
		end
		// Read right after an address write must wait
		reg_wr(ME, 1'b1, 32'h0);
		for (k = 0; k < 3; k++) begin
			@(negedge clk);
			check("read_stall", 0, oct_ready);
		end
		octal(1'b0, 1'b0, a);
		// Refresh at a short programmed interval
		reg_wr(BCAST_ID, 1'b0, cmdw(OP_REFRESH, 0, 14'd40));
		for (k = 0; k < 17000 && cache_status_reg[ST_REFPEND] !== 1'b1; k++) @(negedge clk);
		check("ref_pending", 1, cache_status_reg[ST_REFPEND]);
		check("ref_blocks", 0, oct_ready);
		for (k = 0; k < 40 && cache_status_reg[ST_REFPEND] === 1'b1; k++) @(negedge clk);
		for (t0 = 0; t0 < 60 && cache_status_reg[ST_REFPEND] !== 1'b1; t0++) @(negedge clk);
		check("ref_period", 1, t0 >= 30 && t0 <= 46);
		repeat (3) @(negedge clk);
		check("rd_q_left", 0, rd_q.size());
		check("pf_q_left", 0, pf_q.size());
		tally_and_finish();
	end
endmodule
